// File: core/gpio_defines.svh
// Purpose: Register indices, field positions, reset values and pin groups of the GPIO output block
// Assumes: Register byte address is four times the register index
// Notes:   Definitions only
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// --------------------------------------------------------------------------
// Register indices
// --------------------------------------------------------------------------
`define IDX_HIGH_BYTE_OUT_DATA     7'h40
`define IDX_HIGH_BYTE_OUT_ENABLE   7'h42
`define IDX_GROUP_SELECT           7'h44
`define IDX_TOP_NIBBLE_OUT_DATA    7'h45
`define IDX_TOP_NIBBLE_OUT_ENABLE  7'h47
`define IDX_LOW_BYTE_OUT_DATA      7'h48
`define IDX_LOW_BYTE_OUT_ENABLE    7'h4A

// --------------------------------------------------------------------------
// Fields, reset values and pin groups
// --------------------------------------------------------------------------
`define GROUP0_SELECT_BIT          0
`define GROUP1_SELECT_BIT          1
`define TOP_NIBBLE_BITS            4
`define REG_RESET_VALUE            8'h00
`define GROUP0_PIN_MASK            20'h3_0F00
`define GROUP1_PIN_MASK            20'hC_F000
`define UNGROUPED_PIN_MASK         20'h0_00FF

`endif

// File: core/gpio_pkg.sv
// Purpose: Types shared by the GPIO output block
// Assumes: Nothing beyond the defines header
// Notes:   Constants live in gpio_defines.svh
package gpio_pkg;

  // Register byte as stored
  typedef logic [7:0] reg_byte_t;

  // Avalon handshake phases
  typedef enum logic [0:0] {HS_IDLE, HS_ANSWER} handshake_t;

endpackage : gpio_pkg

// File: core/pin_drive_if.sv
// Purpose: Carries per-pin drive requests to the driver bank and its registered pin outputs back
// Assumes: One clock domain
// Notes:   Width is the number of pins
`timescale 1ns/1ns
interface pin_drive_if #(parameter int N_PINS = 20);
  logic [N_PINS-1:0] level;
  logic [N_PINS-1:0] enable;
  logic [N_PINS-1:0] pin_out;
  logic [N_PINS-1:0] pin_oe_n;

  modport ctrl (output level, output enable, input pin_out, input pin_oe_n);
  modport bank (input level, input enable, output pin_out, output pin_oe_n);
endinterface : pin_drive_if

// File: core/gpio_driver_bank.sv
// Purpose: Registers the output level and active-low driver enable of each pin
// Assumes: Enable already combines the enable bit and the group grant
// Notes:   Every pin output comes straight from a flip-flop
`timescale 1ns/1ns
module gpio_driver_bank #(
  parameter int N_PINS = 20
) (
  input  wire logic clk,
  input  wire logic rst_n,
  pin_drive_if.bank drv
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (N_PINS < 1) begin : g_bad_width
    $error("gpio_driver_bank needs at least one pin");
  end

  // --------------------------------------------------------------------------
  // Pin drive registers
  // --------------------------------------------------------------------------
  // Disabled pins also drive a low level internally so nothing floats inside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv.pin_out  <= '0;
      drv.pin_oe_n <= '1;
    end else begin
      drv.pin_out  <= drv.level & drv.enable;
      drv.pin_oe_n <= ~drv.enable;
    end
  end

endmodule : gpio_driver_bank

// File: core/gpio_output_block.sv
// Purpose: Write-only GPIO output data, driver enable and group select registers behind Avalon-MM
// Assumes: Pin inputs synchronous to clk; byte address is four times the register index
// Notes:   Reads at data offsets return live pin levels; other reads return zero
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
`include "gpio_defines.svh"

// Notes on behaviour
// [R1] Register 0x48 bits 0..7 set output levels of pins 0..7.
// [R2] Register 0x40 bits 0..7 set output levels of pins 8..15.
// [R3] Register 0x45 bits 0..3 set levels of pins 16..19; upper bits reserved.
// [R4] Enable bit one turns the driver on; zero tristates it, pin is input.
// [R5] Register 0x42 bits 0..7 enable drivers of pins 8..15.
// [R6] Another enable register: bits 0..3 enable pins 16..19, upper bits reserved.
// [R7] Twelve shared pins form two groups of six, each switched by one bit.
// [R8] Select bit 0 one gives pins 8..11, 16, 17 to GPIO; zero to line 0.
// [R9] Select bit 1 one gives pins 12..15, 18, 19 to GPIO; zero to line 1.
// [R10] Group select gates only drivers; pin inputs are always sampled.
// [R11] All data, enable and select bits clear on reset; all drivers off.
// [R12] Group select zero keeps all six group outputs disabled whatever enables say.
// [R13] Pin levels are readable at the same addresses as the output registers.
// [R14] Software writes zero to all reserved bits.
module gpio_output_block
  import gpio_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int N_PINS = 20
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic [N_PINS-1:0] pin_in,
  output logic      [N_PINS-1:0] pin_out,
  output logic      [N_PINS-1:0] pin_oe_n,
  output logic                   line0_owns_pins,
  output logic                   line1_owns_pins
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (ADDR_W < 9) begin : g_bad_addr
    $error("gpio_output_block needs at least 9 address bits");
  end
  if (N_PINS != 20) begin : g_bad_pins
    $error("gpio_output_block serves exactly 20 pins");
  end

  // --------------------------------------------------------------------------
  // Registers and handshake state
  // --------------------------------------------------------------------------
  reg_byte_t  low_byte_out_data_reg;
  reg_byte_t  high_byte_out_data_reg;
  reg_byte_t  top_nibble_out_data_reg;
  reg_byte_t  low_byte_out_enable_reg;
  reg_byte_t  high_byte_out_enable_reg;
  reg_byte_t  top_nibble_out_enable_reg;
  logic [1:0] group_select_reg;
  handshake_t hs_state;
  logic       wr_fire;
  logic       rd_fire;
  logic       word_hit;
  logic [6:0] reg_index;
  logic [31:0] next_readdata;
  logic [N_PINS-1:0] granted;

  pin_drive_if #(.N_PINS(N_PINS)) drv ();

  assign reg_index = address[8:2];
  // Every address bit above the register window must be zero, so wider buses do not alias the block
  assign word_hit  = (address[1:0] == 2'b00) && ((address >> 9) == '0);
  assign wr_fire   = write && !waitrequest;
  assign rd_fire   = read && !waitrequest;

  // --------------------------------------------------------------------------
  // Avalon handshake
  // --------------------------------------------------------------------------
  // One wait cycle, then a single answer cycle with waitrequest low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_state    <= HS_IDLE;
      waitrequest <= 1'b1;
    end else if (hs_state == HS_IDLE && (read || write)) begin
      hs_state    <= HS_ANSWER;
      waitrequest <= 1'b0;
    end else begin
      hs_state    <= HS_IDLE;
      waitrequest <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Pin levels are visible regardless of group select or enables
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (word_hit) begin
      unique case (reg_index)
        `IDX_LOW_BYTE_OUT_DATA:   next_readdata[7:0] = pin_in[7:0];     // R13 R10
        `IDX_HIGH_BYTE_OUT_DATA:  next_readdata[7:0] = pin_in[15:8];    // R13 R10
        `IDX_TOP_NIBBLE_OUT_DATA: next_readdata[3:0] = pin_in[19:16];   // R13 R10
        default:                  next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data captured at the edge that lowers waitrequest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (hs_state == HS_IDLE && read) begin
      readdata <= next_readdata;
    end
  end

  // --------------------------------------------------------------------------
  // Output data registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_byte_out_data_reg   <= `REG_RESET_VALUE;   // R11
      high_byte_out_data_reg  <= `REG_RESET_VALUE;   // R11
      top_nibble_out_data_reg <= `REG_RESET_VALUE;   // R11
    end else if (wr_fire && word_hit && byteenable[0]) begin
      if (reg_index == `IDX_LOW_BYTE_OUT_DATA) begin
        low_byte_out_data_reg <= writedata[7:0];     // R1
      end
      if (reg_index == `IDX_HIGH_BYTE_OUT_DATA) begin
        high_byte_out_data_reg <= writedata[7:0];    // R2
      end
      if (reg_index == `IDX_TOP_NIBBLE_OUT_DATA) begin
        top_nibble_out_data_reg <= {4'h0, writedata[3:0]};   // R3
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output enable registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_byte_out_enable_reg   <= `REG_RESET_VALUE;   // R11
      high_byte_out_enable_reg  <= `REG_RESET_VALUE;   // R11
      top_nibble_out_enable_reg <= `REG_RESET_VALUE;   // R11
    end else if (wr_fire && word_hit && byteenable[0]) begin
      if (reg_index == `IDX_LOW_BYTE_OUT_ENABLE) begin
        low_byte_out_enable_reg <= writedata[7:0];
      end
      if (reg_index == `IDX_HIGH_BYTE_OUT_ENABLE) begin
        high_byte_out_enable_reg <= writedata[7:0];   // R5
      end
      if (reg_index == `IDX_TOP_NIBBLE_OUT_ENABLE) begin
        top_nibble_out_enable_reg <= {4'h0, writedata[3:0]};   // R6
      end
    end
  end

  // --------------------------------------------------------------------------
  // Group select register
  // --------------------------------------------------------------------------
  // Reserved upper bits are dropped; software keeps them zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      group_select_reg <= 2'b00;   // R11
    end else if (wr_fire && word_hit && byteenable[0] && reg_index == `IDX_GROUP_SELECT) begin
      group_select_reg <= writedata[1:0];   // R7 R14
    end
  end

  // Tells the line interfaces which groups they still own
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line0_owns_pins <= 1'b1;
      line1_owns_pins <= 1'b1;
    end else begin
      line0_owns_pins <= !group_select_reg[`GROUP0_SELECT_BIT];   // R8
      line1_owns_pins <= !group_select_reg[`GROUP1_SELECT_BIT];   // R9
    end
  end

  // --------------------------------------------------------------------------
  // Driver gating
  // --------------------------------------------------------------------------
  // Each group grant covers all six of its pins as a whole
  assign granted = `UNGROUPED_PIN_MASK
                 | ({N_PINS{group_select_reg[`GROUP0_SELECT_BIT]}} & `GROUP0_PIN_MASK)   // R7 R8 R12
                 | ({N_PINS{group_select_reg[`GROUP1_SELECT_BIT]}} & `GROUP1_PIN_MASK);  // R7 R9 R12

  assign drv.level  = {top_nibble_out_data_reg[3:0], high_byte_out_data_reg, low_byte_out_data_reg};
  assign drv.enable = granted & {top_nibble_out_enable_reg[3:0], high_byte_out_enable_reg,
                                 low_byte_out_enable_reg};   // R4 R10

  gpio_driver_bank #(.N_PINS(N_PINS)) u_bank (
    .clk   (clk),
    .rst_n (rst_n),
    .drv   (drv.bank)
  );

  assign pin_out  = drv.pin_out;
  assign pin_oe_n = drv.pin_oe_n;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic any_write_seen;

  // Remembers whether any bus write, to any address, has been accepted since reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      any_write_seen <= 1'b0;
    end else if (wr_fire) begin
      any_write_seen <= 1'b1;
    end
  end

  property p_low_data;
    @(posedge clk) disable iff (!rst_n)
    wr_fire && word_hit && byteenable[0] && reg_index == `IDX_LOW_BYTE_OUT_DATA && low_byte_out_enable_reg == 8'hFF
    ##1 low_byte_out_enable_reg == 8'hFF |-> ##1 pin_out[7:0] == $past(writedata[7:0], 2);
  endproperty
  a_low_data: assert property (p_low_data) else $error("low byte pins do not follow written data"); // R1

  property p_high_data;
    @(posedge clk) disable iff (!rst_n)
    wr_fire && word_hit && byteenable[0] && reg_index == `IDX_HIGH_BYTE_OUT_DATA
    |-> ##2 (pin_out[15:8] == ($past(writedata[7:0], 2) & ~pin_oe_n[15:8]));
  endproperty
  a_high_data: assert property (p_high_data) else $error("high byte pins do not follow written data"); // R2

  property p_top_data;
    @(posedge clk) disable iff (!rst_n)
    wr_fire && word_hit && byteenable[0] && reg_index == `IDX_TOP_NIBBLE_OUT_DATA
    |-> ##2 (pin_out[19:16] == ($past(writedata[3:0], 2) & ~pin_oe_n[19:16]));
  endproperty
  a_top_data: assert property (p_top_data) else $error("top nibble pins do not follow written data"); // R3

  property p_enable_off;
    @(posedge clk) disable iff (!rst_n)
    !low_byte_out_enable_reg[3] |=> pin_oe_n[3] && !pin_out[3];
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("pin driven while its enable is zero"); // R4

  property p_high_enable;
    @(posedge clk) disable iff (!rst_n)
    wr_fire && word_hit && byteenable[0] && reg_index == `IDX_HIGH_BYTE_OUT_ENABLE && group_select_reg == 2'b11
    |-> ##2 pin_oe_n[15:8] == ~$past(writedata[7:0], 2);
  endproperty
  a_high_enable: assert property (p_high_enable) else $error("high byte drivers do not follow enable write"); // R5

  property p_top_enable;
    @(posedge clk) disable iff (!rst_n)
    wr_fire && word_hit && byteenable[0] && reg_index == `IDX_TOP_NIBBLE_OUT_ENABLE && group_select_reg == 2'b11
    |-> ##2 pin_oe_n[19:16] == ~$past(writedata[3:0], 2);
  endproperty
  a_top_enable: assert property (p_top_enable) else $error("top nibble drivers do not follow enable write"); // R6

  property p_group0_on;
    @(posedge clk) disable iff (!rst_n)
    group_select_reg[0] && top_nibble_out_enable_reg[1] |=> !pin_oe_n[17] && !line0_owns_pins;
  endproperty
  a_group0_on: assert property (p_group0_on) else $error("group 0 pin 17 not driven when granted"); // R8

  property p_group1_on;
    @(posedge clk) disable iff (!rst_n)
    group_select_reg[1] && high_byte_out_enable_reg[4] |=> !pin_oe_n[12] && !line1_owns_pins;
  endproperty
  a_group1_on: assert property (p_group1_on) else $error("group 1 pin 12 not driven when granted"); // R9

  property p_group_off;
    @(posedge clk) disable iff (!rst_n)
    (!group_select_reg[0] |=> (&pin_oe_n[11:8]) && (&pin_oe_n[17:16]))
    and (!group_select_reg[1] |=> (&pin_oe_n[15:12]) && (&pin_oe_n[19:18]));
  endproperty
  a_group_off: assert property (p_group_off) else $error("pin of a line-owned group is driven"); // R12

  property p_reset_clear;
    @(posedge clk) disable iff (!rst_n)
    !any_write_seen |-> (&pin_oe_n) && pin_out == '0 && line0_owns_pins && line1_owns_pins;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("drivers active before any write"); // R11

  property p_pin_read;
    @(posedge clk) disable iff (!rst_n)
    rd_fire && word_hit && reg_index == `IDX_HIGH_BYTE_OUT_DATA |-> readdata == {24'h00_0000, $past(pin_in[15:8])};
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read does not return pin levels"); // R13

  property p_top_read;
    @(posedge clk) disable iff (!rst_n)
    rd_fire && word_hit && reg_index == `IDX_TOP_NIBBLE_OUT_DATA && group_select_reg == 2'b00
    |-> readdata == {28'h000_0000, $past(pin_in[19:16])};
  endproperty
  a_top_read: assert property (p_top_read) else $error("pin read blocked while group unselected"); // R10

  c_group0_write: cover property (@(posedge clk) disable iff (!rst_n)
    wr_fire && reg_index == `IDX_GROUP_SELECT && writedata[0]);
  c_pin_driven: cover property (@(posedge clk) disable iff (!rst_n) !pin_oe_n[16] && pin_out[16]);
  c_pin_read: cover property (@(posedge clk) disable iff (!rst_n) rd_fire && reg_index == `IDX_LOW_BYTE_OUT_DATA);

endmodule : gpio_output_block

// File: bench/board_model.sv
// Purpose: Board circuitry on the GPIO pins; resolves each pin from the device driver and the board level
// Assumes: Board holds its own level on every pin that the device does not drive
// Notes:   Board level is changed by the bench before each random operation, so a stale value cannot pass
`timescale 1ns/1ns
module board_model #(
  parameter int N_PINS = 20
) (
  input  wire logic [N_PINS-1:0] pin_out,
  input  wire logic [N_PINS-1:0] pin_oe_n,
  input  wire logic [N_PINS-1:0] board_level,
  output logic      [N_PINS-1:0] pin_in
);
  // Device level where its driver is on (enable active low), board level elsewhere
  assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
endmodule : board_model

// File: bench/tb_top.sv
// Purpose: Self-checking bench of the GPIO output block with Avalon-MM master and board model
// Assumes: Master waits up to 20 cycles for waitrequest low, then fails the run; pins settle within three edges
// Notes:   Random writes and reads from a fixed seed, with group-select corner cases
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  // ----------------------------------------------------------------
  // Signals and reference model
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic [8:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [19:0] pin_in;
  logic [19:0] pin_out;
  logic [19:0] pin_oe_n;
  logic        line0_owns_pins;
  logic        line1_owns_pins;
  logic [19:0] board_level;
  logic [7:0]  m_ld, m_hd, m_le, m_he;
  logic [3:0]  m_td, m_te;
  logic [1:0]  m_sel;
  logic [31:0] q;
  int          failures, checks, seed, k, i;
  logic [8:0]  regs [8] = '{9'h100, 9'h108, 9'h110, 9'h114, 9'h11C, 9'h120, 9'h128, 9'h124};

  gpio_output_block u_gpio_output_block (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .line0_owns_pins(line0_owns_pins), .line1_owns_pins(line1_owns_pins));
  board_model u_board_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_level(board_level),
    .pin_in(pin_in));

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [19:0] drv();
    logic [19:0] g;
    g = 20'h0_00FF | (m_sel[0] ? 20'h3_0F00 : 20'h0_0000) | (m_sel[1] ? 20'hC_F000 : 20'h0_0000);
    return {m_te, m_he, m_le} & g;
  endfunction : drv
  function automatic logic [19:0] lvl();
    return {m_td, m_hd, m_ld} & drv();
  endfunction : lvl
  function automatic logic [31:0] exp_rd(input logic [8:0] a);
    logic [19:0] w;
    w = lvl() | (board_level & ~drv());
    case (a)
      9'h100:  return {24'h00_0000, w[15:8]};
      9'h114:  return {28'h000_0000, w[19:16]};
      9'h120:  return {24'h00_0000, w[7:0]};
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_rd

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic [8:0] a, input logic rd, input logic [7:0] d, input logic be0);
    int n;
    @(posedge clk);
    address <= a;
    read <= rd;
    write <= ~rd;
    writedata <= {24'h00_0000, d};
    byteenable <= {3'b111, be0};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      end_of_test();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // Write that also updates the reference model
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic be0);
    bus(a, 1'b0, d, be0);
    if (be0) begin
      case (a)
        9'h100: m_hd = d;
        9'h108: m_he = d;
        9'h110: m_sel = d[1:0];
        9'h114: m_td = d[3:0];
        9'h11C: m_te = d[3:0];
        9'h120: m_ld = d;
        9'h128: m_le = d;
        default: ;
      endcase
    end
  endtask : wr

  // Settle, then compare pins, line ownership and one read
  task automatic check_all(input logic [8:0] ra);
    repeat (3) @(posedge clk);
    `CHK(pin_oe_n, ~drv())
    `CHK(pin_out, lvl())
    `CHK({line1_owns_pins, line0_owns_pins}, ~m_sel)
    bus(ra, 1'b1, 8'h00, 1'b1);
    `CHK(q, exp_rd(ra))
  endtask : check_all

  task automatic clear_model();
    {m_ld, m_hd, m_le, m_he, m_td, m_te, m_sel} = '0;
  endtask : clear_model

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h6c49;
    failures = 0;
    checks = 0;
    clear_model();
    rst_n = 1'b0;
    {address, read, write, writedata, byteenable} = '0;
    board_level = 20'hA_5C3A;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    check_all(9'h100);
    // Every driver on, then all four group-select codes
    wr(9'h108, 8'hFF, 1'b1);
    wr(9'h11C, 8'h0F, 1'b1);
    wr(9'h128, 8'hFF, 1'b1);
    wr(9'h100, 8'h5A, 1'b1);
    wr(9'h114, 8'h09, 1'b1);
    wr(9'h120, 8'hA5, 1'b1);
    for (k = 0; k < 4; k++) begin
      wr(9'h110, k[7:0], 1'b1);
      check_all(9'h114);
      check_all(9'h100);
    end
    // Both groups granted: enable writes reach the pins directly
    wr(9'h108, 8'h3C, 1'b1);
    wr(9'h11C, 8'h05, 1'b1);
    check_all(9'h120);
    // Random writes, refused writes and reads
    for (i = 0; i < 300; i++) begin
      board_level <= 20'($random(seed));
      k = {$random(seed)} % 10;
      q = $random(seed);
      if (k < 7) begin
        wr(regs[k], (k == 2) ? (q[7:0] & 8'h03) : (k == 3 || k == 4) ? (q[7:0] & 8'h0F) : q[7:0], 1'b1);
      end else if (k == 7) begin
        wr(9'h124, q[7:0], 1'b1);
      end else if (k == 8) begin
        wr(regs[q[10:8]] | 9'h002, q[7:0], 1'b1);
      end else begin
        wr(regs[q[10:8]], q[7:0], 1'b0);
      end
      check_all(regs[{$random(seed)} % 8]);
    end
    // Reset in mid-run clears everything
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(pin_oe_n, 20'hF_FFFF)
    `CHK(pin_out, 20'h0_0000)
    `CHK({line1_owns_pins, line0_owns_pins, waitrequest}, 3'b111)
    rst_n <= 1'b1;
    clear_model();
    check_all(9'h120);
    end_of_test();
  end

  // Bound on the whole run
  initial begin
    #4_000_000;
    failures++;
    end_of_test();
  end
endmodule : tb_top
